// ===== core/tcth_pkg.sv
// Purpose: Shared constants and types of the thermometer/thermostat core
// Assumes: 125 MHz core clock
// Notes:   Command codes are local to this core
package tcth_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ          = 125;
    localparam int CONV9_TIME_US    = 93750;  // 9-bit conversion, 93.75 ms
    localparam int CONV9_CYCLES     = CONV9_TIME_US * CLK_MHZ;
    localparam int NV_WRITE_TIME_US = 10000;  // Nonvolatile write, 10 ms
    localparam int NV_WRITE_CYCLES  = NV_WRITE_TIME_US * CLK_MHZ;

    // ****************************************************************
    // Reset and factory values
    // ****************************************************************
    localparam logic [15:0] TEMP_RESET   = 16'hc400;
    localparam logic [15:0] UPPER_FACTORY = 16'h0f00;
    localparam logic [15:0] LOWER_FACTORY = 16'h0a00;
    localparam logic [1:0]  NVBITS_FACTORY = 2'h0;
    localparam logic [1:0]  RES_RESET    = 2'h3;

    // ****************************************************************
    // Configuration byte layout
    // ****************************************************************
    localparam int CFG_DONE_BIT   = 7;
    localparam int CFG_HIGH_BIT   = 6;
    localparam int CFG_LOW_BIT    = 5;
    localparam int CFG_NVBUSY_BIT = 4;
    localparam int CFG_RES_HI_BIT = 3;
    localparam int CFG_RES_LO_BIT = 2;
    localparam int CFG_LEVEL_BIT  = 1;
    localparam int CFG_SINGLE_BIT = 0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        TCTH_CMD_NONE   = 3'h0,
        TCTH_CMD_BEGIN  = 3'h1,
        TCTH_CMD_HALT   = 3'h2,
        TCTH_CMD_TEMP   = 3'h3,
        TCTH_CMD_UPPER  = 3'h4,
        TCTH_CMD_LOWER  = 3'h5,
        TCTH_CMD_CONFIG = 3'h6,
        TCTH_CMD_SOFTPOR = 3'h7
    } tcth_cmd_e;

    typedef struct packed {
        logic        write;
        tcth_cmd_e   op;
        logic [15:0] wdata;
    } tcth_cmd_s;

    typedef enum logic [1:0] {
        TCTH_IDLE = 2'h0,
        TCTH_CONV = 2'h1
    } tcth_state_e;

endpackage : tcth_pkg

// ===== core/tcth_nvstore.sv
// Purpose: Nonvolatile trip points and level/mode bits with write timer
// Assumes: Reset stands for delivery from the factory
// Notes:   Writes arriving while a write is in flight are dropped
`timescale 1ns/100ps
`default_nettype none
module tcth_nvstore
    import tcth_pkg::*;
#(
    parameter int WRITE_CYCLES = NV_WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Write port
    input  wire logic        wr_upper_i,
    input  wire logic        wr_lower_i,
    input  wire logic        wr_bits_i,
    input  wire logic [15:0] wdata_i,
    // Stored contents
    output logic      [15:0] upper_o,
    output logic      [15:0] lower_o,
    output logic      [1:0]  bits_o,
    output logic             busy_o
);

    logic [31:0] wait_q;
    wire         take_w = !busy_o && (wr_upper_i || wr_lower_i || wr_bits_i);

    // Contents; a write only lands when no other is in flight
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upper_o <= UPPER_FACTORY;
            lower_o <= LOWER_FACTORY;
            bits_o  <= NVBITS_FACTORY;
        end else if (take_w) begin
            if (wr_upper_i) upper_o <= wdata_i;
            if (wr_lower_i) lower_o <= wdata_i;
            if (wr_bits_i)  bits_o  <= wdata_i[1:0];
        end
    end

    // Busy window models the cell programming time
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q <= 32'h0;
            busy_o <= 1'b0;
        end else if (take_w) begin
            wait_q <= 32'(WRITE_CYCLES - 1);
            busy_o <= 1'b1;
        end else if (busy_o) begin
            if (wait_q == 32'h0) busy_o <= 1'b0;
            else                 wait_q <= wait_q - 32'h1;
        end
    end

endmodule : tcth_nvstore
`default_nettype wire

// ===== core/tcth_core.sv
// Purpose: Conversion sequencing and thermostat of a temperature sensor
// Assumes: A front end presents decoded commands on pins, taken at SCL rise
// Notes:   Sense data comes from the analog side and is sampled at the end
`timescale 1ns/100ps
`default_nettype none
module tcth_core
    import tcth_pkg::*;
#(
    parameter bit AUTOSTART       = 1'b0,
    parameter int CONV9_COUNT     = CONV9_CYCLES,
    parameter int NV_WRITE_COUNT  = NV_WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Link pins from the 2-wire front end
    input  wire logic        scl_i,
    input  wire logic        cmd_valid_i,
    input  wire tcth_cmd_s   cmd_i,
    output logic      [15:0] rdata_o,
    output logic             rvalid_o,
    // Analog side
    input  wire logic [15:0] sense_temp_i,
    // Thermostat pin
    output logic             alarm_pin_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Keep the top 9..12 bits per resolution code
    function automatic logic [15:0] res_mask(input logic [15:0] v,
                                             input logic [1:0]  res);
        logic [15:0] m;
        m = 16'hfff0 << (2'h3 - res);
        return v & m;
    endfunction : res_mask

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic            scl_m_q, scl_s_q, scl_d_q;
    logic            vld_m_q, vld_s_q;
    tcth_cmd_s       cmd_m_q, cmd_s_q;
    logic [15:0]     sen_m_q, sen_s_q;

    // Two stages on every pin and a third on SCL; the second stage is read, the third only for the SCL edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_d_q <= 1'b1;
            vld_m_q <= 1'b0;
            vld_s_q <= 1'b0;
            cmd_m_q <= '0;
            cmd_s_q <= '0;
            sen_m_q <= 16'h0;
            sen_s_q <= 16'h0;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_d_q <= scl_s_q;
            vld_m_q <= cmd_valid_i;
            vld_s_q <= vld_m_q;
            cmd_m_q <= cmd_i;
            cmd_s_q <= cmd_m_q;
            sen_m_q <= sense_temp_i;
            sen_s_q <= sen_m_q;
        end
    end

    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic [1:0]  res_q;
    logic        high_q, low_q, done_q, active_q, pend_q;
    logic [15:0] temp_q;
    logic [31:0] cnt_q;
    tcth_state_e state_q;
    logic [15:0] upper_w, lower_w;
    logic [1:0]  nvbits_w;
    logic        nvbusy_w;

    // A command is taken on the synchronised rising edge of the link clock
    wire take_w     = scl_s_q && !scl_d_q && vld_s_q;
    wire op_begin_w = take_w && cmd_s_q.op == TCTH_CMD_BEGIN;
    wire op_halt_w  = take_w && cmd_s_q.op == TCTH_CMD_HALT;
    wire op_por_w   = take_w && cmd_s_q.op == TCTH_CMD_SOFTPOR;
    wire wr_w       = take_w && cmd_s_q.write;
    wire wr_up_w    = wr_w && cmd_s_q.op == TCTH_CMD_UPPER;
    wire wr_lo_w    = wr_w && cmd_s_q.op == TCTH_CMD_LOWER;
    wire wr_cfg_w   = wr_w && cmd_s_q.op == TCTH_CMD_CONFIG;
    wire wr_bits_w  = wr_cfg_w && cmd_s_q.wdata[1:0] != nvbits_w;
    wire single_w   = nvbits_w[CFG_SINGLE_BIT];
    wire level_w    = nvbits_w[CFG_LEVEL_BIT];

    // Trip points as seen through the resolution mask
    wire [15:0] up_m_w = res_mask(upper_w, res_q);
    wire [15:0] lo_m_w = res_mask(lower_w, res_q);

    // Configuration byte with live status bits
    wire [7:0] cfg_w = {done_q, high_q, low_q, nvbusy_w,
                        res_q, level_w, single_w};

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************

    // 9-bit time shifted up by the resolution code
    wire [31:0] conv_len_w = 32'(CONV9_COUNT) << res_q;
    wire        conv_end_w = state_q == TCTH_CONV &&
                             cnt_q == conv_len_w - 32'h1;
    wire [15:0] result_w   = res_mask(sen_s_q, res_q);
    wire        ge_up_w    = $signed(result_w) >= $signed(up_m_w);
    wire        gt_up_w    = $signed(result_w) >  $signed(up_m_w);
    wire        lt_lo_w    = $signed(result_w) <  $signed(lo_m_w);

    // Run state; autostart pends a begin from reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= TCTH_IDLE;
            pend_q  <= AUTOSTART;
            cnt_q   <= 32'h0;
            done_q  <= 1'b1;
        end else begin
            case (state_q)
                TCTH_IDLE: begin
                    cnt_q <= 32'h0;
                    if (op_begin_w || pend_q) begin
                        state_q <= TCTH_CONV;
                        pend_q  <= 1'b0;
                        done_q  <= 1'b0;
                    end
                end
                TCTH_CONV: begin
                    if (op_halt_w || op_por_w) begin
                        state_q <= TCTH_IDLE;
                        done_q  <= 1'b1;
                    end else if (conv_end_w) begin
                        cnt_q <= 32'h0;
                        if (single_w) begin
                            state_q <= TCTH_IDLE;
                            done_q  <= 1'b1;
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= TCTH_IDLE;
                    done_q  <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Result, alarm and flags
    // ****************************************************************

    // Everything judged from the result in the cycle it is stored
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            temp_q   <= TEMP_RESET;
            active_q <= 1'b0;
        end else if (conv_end_w && !op_halt_w && !op_por_w) begin
            temp_q <= result_w;
            if (ge_up_w)      active_q <= 1'b1;
            else if (lt_lo_w) active_q <= 1'b0;
        end
    end

    wire stored_w = conv_end_w && !op_halt_w && !op_por_w;

    // Flags: a new excursion wins over a clearing write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            high_q <= 1'b0;
            low_q  <= 1'b0;
            res_q  <= RES_RESET;
        end else if (op_por_w) begin
            high_q <= 1'b0;
            low_q  <= 1'b0;
            res_q  <= RES_RESET;
        end else begin
            if (stored_w && gt_up_w) high_q <= 1'b1;
            else if (wr_cfg_w && !cmd_s_q.wdata[CFG_HIGH_BIT]) high_q <= 1'b0;
            if (stored_w && lt_lo_w) low_q <= 1'b1;
            else if (wr_cfg_w && !cmd_s_q.wdata[CFG_LOW_BIT]) low_q <= 1'b0;
            if (wr_cfg_w)
                res_q <= cmd_s_q.wdata[CFG_RES_HI_BIT:CFG_RES_LO_BIT];
        end
    end

    // Asserted level chosen by the stored level bit
    assign alarm_pin_o = level_w ? active_q : !active_q;

    // ****************************************************************
    // Read answers
    // ****************************************************************

    // Read data is registered; one-cycle valid per taken read
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o  <= 16'h0;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= take_w && !cmd_s_q.write &&
                        (cmd_s_q.op == TCTH_CMD_TEMP  ||
                         cmd_s_q.op == TCTH_CMD_UPPER ||
                         cmd_s_q.op == TCTH_CMD_LOWER ||
                         cmd_s_q.op == TCTH_CMD_CONFIG);
            if (take_w && !cmd_s_q.write) begin
                case (cmd_s_q.op)
                    TCTH_CMD_TEMP:   rdata_o <= temp_q;
                    TCTH_CMD_UPPER:  rdata_o <= up_m_w;
                    TCTH_CMD_LOWER:  rdata_o <= lo_m_w;
                    TCTH_CMD_CONFIG: rdata_o <= {8'h00, cfg_w};
                    default:         rdata_o <= rdata_o;
                endcase
            end
        end
    end

    // ****************************************************************
    // Nonvolatile store
    // ****************************************************************
    tcth_nvstore #(
        .WRITE_CYCLES (NV_WRITE_COUNT)
    ) u_nv (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .wr_upper_i (wr_up_w),
        .wr_lower_i (wr_lo_w),
        .wr_bits_i  (wr_bits_w),
        .wdata_i    (cmd_s_q.wdata),
        .upper_o    (upper_w),
        .lower_o    (lower_w),
        .bits_o     (nvbits_w),
        .busy_o     (nvbusy_w)
    );

endmodule : tcth_core
`default_nettype wire

// ===== test/tcth_checker.sv
// Purpose: Port assertions for the conversion and thermostat core
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Answer bounds allow for the input synchronisers
`timescale 1ns/100ps
`default_nettype none
module tcth_checker
    import tcth_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    // Link side
    input wire logic        scl_i,
    input wire logic        cmd_valid_i,
    input wire tcth_cmd_s   cmd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        rvalid_o,
    // Analog side and pin
    input wire logic [15:0] sense_temp_i,
    input wire logic        alarm_pin_o
);
    // ********************
    // Helper state
    // ********************
    tcth_cmd_e  last_op_q;
    logic       last_wr_q;
    logic       scl_q;
    wire logic  take_w = scl_i & ~scl_q & cmd_valid_i;
    wire logic  rd_w   = ~cmd_i.write & (cmd_i.op >= TCTH_CMD_TEMP)
                         & (cmd_i.op <= TCTH_CMD_CONFIG);

    // Opcode of the last command, so an answer can be judged by kind
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_q     <= 1'b0;
            last_op_q <= TCTH_CMD_NONE;
            last_wr_q <= 1'b0;
        end else begin
            scl_q <= scl_i;
            if (take_w) begin
                last_op_q <= cmd_i.op;
                last_wr_q <= cmd_i.write;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // Answers: only for reads, once, and data moves only with them
    read_answer_a: assert property (
        take_w && rd_w |-> ##[2:6] rvalid_o)
        else $error("read got no answer");
    no_answer_a: assert property (
        take_w && !rd_w |-> ##1 !rvalid_o [*7])
        else $error("answer without a read");
    pulse_once_a: assert property (rvalid_o |=> !rvalid_o)
        else $error("answer strobe longer than one cycle");
    rdata_hold_a: assert property (
        $changed(rdata_o) |-> rvalid_o)
        else $error("read data moved without an answer");
    answer_kind_a: assert property (
        rvalid_o |-> !last_wr_q && (last_op_q inside
        {TCTH_CMD_TEMP, TCTH_CMD_UPPER, TCTH_CMD_LOWER, TCTH_CMD_CONFIG}))
        else $error("answer to a command that is not a read");
    low_nibble_a: assert property (
        rvalid_o && (last_op_q inside
        {TCTH_CMD_TEMP, TCTH_CMD_UPPER, TCTH_CMD_LOWER})
        |-> rdata_o[3:0] == 4'h0)
        else $error("low bits of a word not zero");
    cfg_byte_a: assert property (
        rvalid_o && last_op_q == TCTH_CMD_CONFIG
        |-> rdata_o[15:8] == 8'h00)
        else $error("config answer wider than a byte");
    reset_alarm_a: assert property (
        $rose(arst_n_i) |-> alarm_pin_o)
        else $error("alarm pin active after reset");
endmodule : tcth_checker

bind tcth_core tcth_checker u_chk (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .sense_temp_i(sense_temp_i),
    .alarm_pin_o(alarm_pin_o)
);
`default_nettype wire

// ===== test/tcth_host_model.sv
// Purpose: Bus host that sends one decoded command per link clock rise
// Assumes: Link clock stands low between frames
// Notes:   Released command lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module tcth_host_model
    import tcth_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Command pins
    output var logic         scl_o,
    output var logic         cmd_valid_o,
    output var tcth_cmd_s    cmd_o,
    // Answer
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i
);
    // ********************
    // Host side
    // ********************
    initial begin
        scl_o       = 1'b0;
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
    end

    // Lines set 3 cycles ahead of the rise, held until the fall (56 ns)
    task automatic xfer(input logic wr, input tcth_cmd_e op,
                        input logic [15:0] wd, output logic [15:0] rdata);
        rdata = 16'hxxxx;
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_o = '{write: wr, op: op, wdata: wd};
        repeat (3) @(negedge clk_i);
        scl_o = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_i);
            if (rvalid_i === 1'b1) begin
                rdata = rdata_i;
            end
            if (i == 3) begin
                scl_o = 1'b0;
            end
        end
        cmd_valid_o = 1'b0;
        cmd_o = tcth_cmd_s'(~cmd_o); // Stale value must not pass for live
    endtask : xfer
endmodule : tcth_host_model
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: Self-checking bench of the conversion and thermostat core
// Assumes: Conversion and write counts shortened by parameter
// Notes:   A second core runs the autostart variant on the same link
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import tcth_pkg::*;
;
    // ********************
    // Harness
    // ********************
    logic        clk_i      = 1'b0;
    logic        arst_n_i   = 1'b0;
    logic [15:0] sense_temp = 16'h1000;
    logic        scl, vld, rvalid, alarm, alarm_auto;
    tcth_cmd_s   cmd;
    logic [15:0] rdata;
    int          fails       = 0;
    int          check_count = 0;
    int          cycles      = 0;

    always #4 clk_i = ~clk_i;

    tcth_core #(.CONV9_COUNT(20), .NV_WRITE_COUNT(40))
    u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl),
        .cmd_valid_i(vld), .cmd_i(cmd), .rdata_o(rdata), .rvalid_o(rvalid),
        .sense_temp_i(sense_temp), .alarm_pin_o(alarm));
    tcth_core #(.AUTOSTART(1'b1), .CONV9_COUNT(20), .NV_WRITE_COUNT(40))
    u_auto (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl),
        .cmd_valid_i(vld), .cmd_i(cmd), .rdata_o(), .rvalid_o(),
        .sense_temp_i(sense_temp), .alarm_pin_o(alarm_auto));
    tcth_host_model u_host (.clk_i(clk_i), .scl_o(scl), .cmd_valid_o(vld),
        .cmd_o(cmd), .rdata_i(rdata), .rvalid_i(rvalid));

    // Shared compare, access and wait helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input tcth_cmd_e op, input logic [15:0] exp);
        logic [15:0] v;
        u_host.xfer(1'b0, op, 16'h0000, v);
        check(v, exp);
    endtask : rd
    task automatic wr(input tcth_cmd_e op, input logic [15:0] d);
        logic [15:0] v;
        u_host.xfer(1'b1, op, d, v);
    endtask : wr
    task automatic pin(input logic e);
        check({15'h0000, alarm}, {15'h0000, e});
    endtask : pin
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wt

    // Power-up values; autostart core converts at 12 bits unasked
    task automatic t_reset;
        rd(TCTH_CMD_TEMP, 16'hc400);
        rd(TCTH_CMD_UPPER, 16'h0f00);
        rd(TCTH_CMD_LOWER, 16'h0a00);
        rd(TCTH_CMD_CONFIG, 16'h008c);
        pin(1'b1);
        wr(TCTH_CMD_TEMP, 16'h1234);
        check({15'h0000, alarm_auto}, 16'h0001);
        wt(140);
        check({15'h0000, alarm_auto}, 16'h0000);
        rd(TCTH_CMD_TEMP, 16'hc400);
    endtask : t_reset

    // Trip point masking at 9 bits, write-pending status
    task automatic t_mask;
        wr(TCTH_CMD_CONFIG, 16'h0060);
        wr(TCTH_CMD_UPPER, 16'h0fff);
        rd(TCTH_CMD_CONFIG, 16'h0090);
        wt(50);
        rd(TCTH_CMD_CONFIG, 16'h0080);
        rd(TCTH_CMD_UPPER, 16'h0f80);
        rd(TCTH_CMD_LOWER, 16'h0a00);
    endtask : t_mask

    // One conversion per begin at 10 bits, then idle
    task automatic t_single;
        wr(TCTH_CMD_CONFIG, 16'h0065);
        wt(50);
        sense_temp = 16'h1234;
        wr(TCTH_CMD_BEGIN, 16'h0000);
        rd(TCTH_CMD_CONFIG, 16'h0005);
        wt(40);
        rd(TCTH_CMD_TEMP, 16'h1200);
        rd(TCTH_CMD_CONFIG, 16'h00c5);
        pin(1'b0);
        sense_temp = 16'h0300;
        wt(100);
        rd(TCTH_CMD_TEMP, 16'h1200);
    endtask : t_single

    // Hysteresis band, flag clearing, polarity change
    task automatic t_hyst;
        sense_temp = 16'h0c3f;
        wr(TCTH_CMD_BEGIN, 16'h0000);
        wt(60);
        pin(1'b0);
        rd(TCTH_CMD_TEMP, 16'h0c00);
        sense_temp = 16'h0900;
        wr(TCTH_CMD_BEGIN, 16'h0000);
        pin(1'b0);
        wt(60);
        pin(1'b1);
        rd(TCTH_CMD_CONFIG, 16'h00e5);
        wr(TCTH_CMD_CONFIG, 16'h0005);
        rd(TCTH_CMD_CONFIG, 16'h0085);
        wr(TCTH_CMD_CONFIG, 16'h0067);
        wt(50);
        pin(1'b0);
    endtask : t_hyst

    // Back-to-back conversions until halted
    task automatic t_cont;
        wr(TCTH_CMD_CONFIG, 16'h0066);
        wt(50);
        sense_temp = 16'h1000;
        wr(TCTH_CMD_BEGIN, 16'h0000);
        wt(50);
        pin(1'b1);
        sense_temp = 16'h0500;
        wt(50);
        pin(1'b0);
        wr(TCTH_CMD_HALT, 16'h0000);
        sense_temp = 16'h1000;
        wt(100);
        pin(1'b0);
        rd(TCTH_CMD_CONFIG, 16'h00e6);
    endtask : t_cont

    // 12-bit conversion takes eight 9-bit times
    task automatic t_res;
        wr(TCTH_CMD_CONFIG, 16'h006f);
        wt(50);
        sense_temp = 16'h0717;
        wr(TCTH_CMD_BEGIN, 16'h0000);
        wt(130);
        rd(TCTH_CMD_CONFIG, 16'h006f);
        wt(20);
        rd(TCTH_CMD_CONFIG, 16'h00ef);
        rd(TCTH_CMD_TEMP, 16'h0710);
    endtask : t_res

    // 11-bit masking, then soft reset clears flags and sets resolution back to 12 bits
    task automatic t_softpor;
        wr(TCTH_CMD_CONFIG, 16'h006b);
        rd(TCTH_CMD_UPPER, 16'h0fe0);
        wr(TCTH_CMD_SOFTPOR, 16'h0000);
        rd(TCTH_CMD_CONFIG, 16'h008f);
    endtask : t_softpor

    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d, fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    // Main sequence
    initial begin
        wt(20);
        arst_n_i = 1'b1;
        wt(2);
        t_reset();
        t_mask();
        t_single();
        t_hyst();
        t_cont();
        t_res();
        t_softpor();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
